/* atr_cfg.svh */
`ifndef ATR_CFG_SVH
`define ATR_CFG_SVH

// ----------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------
`define ATR_OFF_CTRL_A 8'h00
`define ATR_OFF_CTRL_B 8'h04
`define ATR_OFF_COUNT 8'h08
`define ATR_OFF_CMP_A 8'h0c
`define ATR_OFF_CMP_B 8'h10
`define ATR_OFF_ASYNC 8'h14
`define ATR_OFF_IEN 8'h18
`define ATR_OFF_FLAGS 8'h1c
`define ATR_OFF_GEN 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATR_B_FORCE_A 7
`define ATR_B_FORCE_B 6
`define ATR_B_WAVE_HI 3
`define ATR_B_EXT_CLOCK_IN_ENABLE 6
`define ATR_B_ASYNC 5
`define ATR_B_TSM 7
`define ATR_B_PSR 1
`define ATR_BUSY_CNT 4
`define ATR_BUSY_CMPA 3
`define ATR_BUSY_CMPB 2
`define ATR_BUSY_CTLA 1
`define ATR_BUSY_CTLB 0
`define ATR_IRQ_B 2
`define ATR_IRQ_A 1
`define ATR_IRQ_OV 0

// ----------------------------------------
// Values
// ----------------------------------------
`define ATR_MAX 8'hff
`define ATR_BOTTOM 8'h00
`define ATR_CTRL_B_MASK 8'h0f
`define ATR_RESET_BYTE 8'h00

`endif

/* atr_pkg.sv */
package atr_pkg;

  typedef enum logic [1:0] {
    ATR_WK_NORMAL = 2'b00,
    ATR_WK_PHASE = 2'b01,
    ATR_WK_CTC = 2'b10,
    ATR_WK_FAST = 2'b11
  } atr_wave_kind_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] cnt;
    logic [7:0] cmpa;
    logic [7:0] cmpb;
    logic [7:0] tmp_ctrl_a;
    logic [7:0] tmp_ctrl_b;
    logic [7:0] tmp_cnt;
    logic [7:0] tmp_cmpa;
    logic [7:0] tmp_cmpb;
    logic [4:0] busy;
    logic ext_clock_in_enable;
    logic async_sel;
    logic [2:0] irq_en;
    logic [2:0] flags;
    logic psr;
    logic timer_sync_hold;
    logic [9:0] presc;
    logic down;
    logic blk;
    logic osc_q;
    logic out_a;
    logic out_b;
    logic oe_a;
    logic oe_b;
    logic ext_buf;
    logic xtal_run;
    logic [2:0] irq;
    logic ack;
    logic [31:0] rdat;
  } atr_state_t;

endpackage : atr_pkg

/* atr_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "atr_cfg.svh"
module atr_timer
  import atr_pkg::*;
#(
  parameter int PRESC_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_pin_i,
  input wire logic global_irq_en_i,
  input wire logic [2:0] irq_vector_ack_i,
  output logic [2:0] irq_req_o,
  output logic wave_out_a_o,
  output logic wave_out_a_en_o,
  output logic wave_out_b_o,
  output logic wave_out_b_en_o,
  output logic ext_clk_buf_en_o,
  output logic xtal_osc_en_o
);

  initial begin
    if (PRESC_W != 10) begin
      $error("PRESC_W must be 10 to reach the divide by 1024 tap");
    end
  end

  // ----------------------------------------
  // Output action helper
  // ----------------------------------------
  function automatic logic wave_match(input logic o, input logic [1:0] com,
                                      input atr_wave_kind_t kind, input logic down,
                                      input logic tog_ok);
    logic r;
    r = o;
    unique case (kind)
      ATR_WK_NORMAL, ATR_WK_CTC: begin
        if (com == 2'b01) r = ~o;
        else if (com == 2'b10) r = 1'b0;
        else if (com == 2'b11) r = 1'b1;
      end
      ATR_WK_FAST: begin
        if (com == 2'b10) r = 1'b0;
        else if (com == 2'b11) r = 1'b1;
        else if (com == 2'b01 && tog_ok) r = ~o;
      end
      ATR_WK_PHASE: begin
        if (com == 2'b10) r = down;
        else if (com == 2'b11) r = ~down;
        else if (com == 2'b01 && tog_ok) r = ~o;
      end
    endcase
    return r;
  endfunction : wave_match

  atr_state_t s_reg;
  atr_state_t s_next;

  logic req;
  logic wr;
  logic rd;
  logic [7:0] d;
  logic osc_edge;
  logic src_tick;
  logic tick;
  logic [2:0] wgm;
  atr_wave_kind_t kind;
  logic [7:0] top;
  logic pwm;
  logic hit_a;
  logic hit_b;
  logic tov;
  logic bottom;
  logic [2:0] set_f;
  logic [2:0] clr_f;
  logic force_a;
  logic force_b;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    req = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wr = req && wb_we_i && wb_sel_i[0];
    rd = req && !wb_we_i;
    d = wb_dat_i[7:0];
    hit_a = 1'b0;
    hit_b = 1'b0;
    tov = 1'b0;
    bottom = 1'b0;
    clr_f = 3'b000;
    force_a = 1'b0;
    force_b = 1'b0;

    // Oscillator pin treated as a plain synchronous input
    osc_edge = osc_pin_i && !s_reg.osc_q;
    s_next.osc_q = osc_pin_i;
    src_tick = s_reg.async_sel ? osc_edge : 1'b1;

    // Power-of-two taps of one free prescaler
    unique case (s_reg.ctrl_b[2:0])
      3'd0: tick = 1'b0;
      3'd1: tick = src_tick;
      3'd2: tick = src_tick && (&s_reg.presc[2:0]);
      3'd3: tick = src_tick && (&s_reg.presc[4:0]);
      3'd4: tick = src_tick && (&s_reg.presc[5:0]);
      3'd5: tick = src_tick && (&s_reg.presc[6:0]);
      3'd6: tick = src_tick && (&s_reg.presc[7:0]);
      3'd7: tick = src_tick && (&s_reg.presc[9:0]);
    endcase

    if (s_reg.psr) begin
      s_next.presc = 10'h000;
      tick = 1'b0;
    end else if (src_tick) begin
      s_next.presc = 10'(s_reg.presc + 10'h001);
    end

    wgm = {s_reg.ctrl_b[`ATR_B_WAVE_HI], s_reg.ctrl_a[1:0]};
    unique case (wgm)
      3'b001, 3'b101: kind = ATR_WK_PHASE;
      3'b010: kind = ATR_WK_CTC;
      3'b011, 3'b111: kind = ATR_WK_FAST;
      default: kind = ATR_WK_NORMAL;
    endcase
    top = (wgm == 3'b010 || wgm == 3'b101 || wgm == 3'b111) ? s_reg.cmpa : `ATR_MAX;
    pwm = (kind == ATR_WK_PHASE) || (kind == ATR_WK_FAST);

    // ----------------------------------------
    // Counting and compare
    // ----------------------------------------
    if (tick) begin
      s_next.blk = 1'b0;
      hit_a = !s_reg.blk && (s_reg.cnt == s_reg.cmpa);
      hit_b = !s_reg.blk && (s_reg.cnt == s_reg.cmpb);
      unique case (kind)
        ATR_WK_NORMAL, ATR_WK_CTC: begin
          s_next.cnt = (s_reg.cnt == top) ? `ATR_BOTTOM : 8'(s_reg.cnt + 8'h01);
          tov = (s_reg.cnt == `ATR_MAX);
        end
        ATR_WK_FAST: begin
          s_next.cnt = (s_reg.cnt == top) ? `ATR_BOTTOM : 8'(s_reg.cnt + 8'h01);
          tov = (s_reg.cnt == top);
          bottom = (s_reg.cnt == top);
        end
        ATR_WK_PHASE: begin
          if (!s_reg.down) begin
            if (s_reg.cnt == top) begin
              s_next.down = 1'b1;
              s_next.cnt = 8'(s_reg.cnt - 8'h01);
            end else begin
              s_next.cnt = 8'(s_reg.cnt + 8'h01);
            end
          end else if (s_reg.cnt == `ATR_BOTTOM) begin
            s_next.down = 1'b0;
            s_next.cnt = 8'(s_reg.cnt + 8'h01);
            tov = 1'b1;
          end else begin
            s_next.cnt = 8'(s_reg.cnt - 8'h01);
          end
        end
      endcase
      if (hit_a) begin
        s_next.out_a = wave_match(s_reg.out_a, s_reg.ctrl_a[7:6], kind, s_reg.down,
                                  s_reg.ctrl_b[`ATR_B_WAVE_HI]);
      end
      if (hit_b) begin
        s_next.out_b = wave_match(s_reg.out_b, s_reg.ctrl_a[5:4], kind, s_reg.down, 1'b0);
      end
      if (bottom) begin
        if (s_reg.ctrl_a[7]) s_next.out_a = !s_reg.ctrl_a[6];
        if (s_reg.ctrl_a[5]) s_next.out_b = !s_reg.ctrl_a[4];
      end
    end
    set_f = {hit_b, hit_a, tov};

    // ----------------------------------------
    // Async transfer from temporary storage
    // ----------------------------------------
    if (s_reg.async_sel && src_tick) begin
      if (s_reg.busy[`ATR_BUSY_CNT]) begin
        s_next.cnt = s_reg.tmp_cnt;
        s_next.blk = 1'b1;
      end
      if (s_reg.busy[`ATR_BUSY_CMPA]) s_next.cmpa = s_reg.tmp_cmpa;
      if (s_reg.busy[`ATR_BUSY_CMPB]) s_next.cmpb = s_reg.tmp_cmpb;
      if (s_reg.busy[`ATR_BUSY_CTLA]) s_next.ctrl_a = s_reg.tmp_ctrl_a;
      if (s_reg.busy[`ATR_BUSY_CTLB]) s_next.ctrl_b = s_reg.tmp_ctrl_b;
      s_next.busy = 5'b00000;
    end

    // Prescaler reset bit release
    if (s_reg.psr && !s_reg.timer_sync_hold && (!s_reg.async_sel || src_tick)) begin
      s_next.psr = 1'b0;
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // No guard on a source switch: registers may hold stale values
    if (wr) begin
      unique case (wb_adr_i)
        `ATR_OFF_CTRL_A: begin
          s_next.tmp_ctrl_a = d;
          if (s_reg.async_sel) s_next.busy[`ATR_BUSY_CTLA] = 1'b1;
          else s_next.ctrl_a = d;
        end
        `ATR_OFF_CTRL_B: begin
          s_next.tmp_ctrl_b = d & `ATR_CTRL_B_MASK;
          if (s_reg.async_sel) s_next.busy[`ATR_BUSY_CTLB] = 1'b1;
          else s_next.ctrl_b = d & `ATR_CTRL_B_MASK;
          force_a = d[`ATR_B_FORCE_A] && !pwm;
          force_b = d[`ATR_B_FORCE_B] && !pwm;
        end
        `ATR_OFF_COUNT: begin
          s_next.tmp_cnt = d;
          if (s_reg.async_sel) begin
            s_next.busy[`ATR_BUSY_CNT] = 1'b1;
          end else begin
            s_next.cnt = d;
            s_next.blk = 1'b1;
          end
        end
        `ATR_OFF_CMP_A: begin
          s_next.tmp_cmpa = d;
          if (s_reg.async_sel) s_next.busy[`ATR_BUSY_CMPA] = 1'b1;
          else s_next.cmpa = d;
        end
        `ATR_OFF_CMP_B: begin
          s_next.tmp_cmpb = d;
          if (s_reg.async_sel) s_next.busy[`ATR_BUSY_CMPB] = 1'b1;
          else s_next.cmpb = d;
        end
        `ATR_OFF_ASYNC: begin
          s_next.ext_clock_in_enable = d[`ATR_B_EXT_CLOCK_IN_ENABLE];
          s_next.async_sel = d[`ATR_B_ASYNC];
        end
        `ATR_OFF_IEN: s_next.irq_en = d[2:0];
        `ATR_OFF_FLAGS: clr_f = d[2:0];
        `ATR_OFF_GEN: begin
          s_next.timer_sync_hold = d[`ATR_B_TSM];
          if (d[`ATR_B_PSR]) s_next.psr = 1'b1;
        end
        default: ;
      endcase
    end

    // Forced match uses the live output modes; no flag, no clear
    if (force_a) begin
      s_next.out_a = wave_match(s_reg.out_a, s_reg.ctrl_a[7:6], ATR_WK_NORMAL, 1'b0, 1'b1);
    end
    if (force_b) begin
      s_next.out_b = wave_match(s_reg.out_b, s_reg.ctrl_a[5:4], ATR_WK_NORMAL, 1'b0, 1'b1);
    end

    // Set wins over a clear in the same cycle
    s_next.flags = (s_reg.flags & ~(clr_f | irq_vector_ack_i)) | set_f;
    s_next.irq = s_next.flags & s_next.irq_en & {3{global_irq_en_i}};

    s_next.oe_a = (s_next.ctrl_a[7:6] != 2'b00);
    s_next.oe_b = (s_next.ctrl_a[5:4] != 2'b00);
    s_next.ext_buf = s_next.ext_clock_in_enable && s_next.async_sel;
    s_next.xtal_run = !s_next.ext_clock_in_enable && s_next.async_sel;

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    s_next.ack = req;
    if (rd) begin
      unique case (wb_adr_i)
        `ATR_OFF_CTRL_A: s_next.rdat = {24'h000000, s_reg.tmp_ctrl_a};
        `ATR_OFF_CTRL_B: s_next.rdat = {24'h000000, s_reg.tmp_ctrl_b};
        `ATR_OFF_COUNT: s_next.rdat = {24'h000000, s_reg.cnt};
        `ATR_OFF_CMP_A: s_next.rdat = {24'h000000, s_reg.tmp_cmpa};
        `ATR_OFF_CMP_B: s_next.rdat = {24'h000000, s_reg.tmp_cmpb};
        `ATR_OFF_ASYNC: s_next.rdat = {25'h0000000, s_reg.ext_clock_in_enable, s_reg.async_sel, s_reg.busy};
        `ATR_OFF_IEN: s_next.rdat = {29'h00000000, s_reg.irq_en};
        `ATR_OFF_FLAGS: s_next.rdat = {29'h00000000, s_reg.flags};
        `ATR_OFF_GEN: s_next.rdat = {24'h000000, s_reg.timer_sync_hold, 5'h00, s_reg.psr, 1'b0};
        default: s_next.rdat = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.rdat;
  assign wb_ack_o = s_reg.ack;
  assign irq_req_o = s_reg.irq;
  assign wave_out_a_o = s_reg.out_a;
  assign wave_out_a_en_o = s_reg.oe_a;
  assign wave_out_b_o = s_reg.out_b;
  assign wave_out_b_en_o = s_reg.oe_b;
  assign ext_clk_buf_en_o = s_reg.ext_buf;
  assign xtal_osc_en_o = s_reg.xtal_run;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  property p_ctrl_b_read;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `ATR_OFF_CTRL_B |-> wb_dat_o[7:4] == 4'h0;
  endproperty
  a_ctrl_b_read: assert property (p_ctrl_b_read) else $error("control B upper bits not zero");

  property p_flag_cause;
    $rose(s_reg.flags[1]) |-> $past(hit_a);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("match A flag without match");

  property p_pwm_force;
    force_a |-> !pwm;
  endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("force honoured in PWM mode");

  property p_busy_set;
    wr && wb_adr_i == `ATR_OFF_COUNT && s_reg.async_sel |=> s_reg.busy[`ATR_BUSY_CNT];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("count busy not set");

  property p_irq_req;
    ##1 irq_req_o == $past(s_next.flags & s_next.irq_en & {3{global_irq_en_i}});
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("request not equal to gated flags");

  property p_psr_sync;
    s_reg.psr && !s_reg.async_sel && !s_reg.timer_sync_hold && !wr |=> !s_reg.psr;
  endproperty
  a_psr_sync: assert property (p_psr_sync) else $error("prescaler reset bit stuck");

  property p_psr_hold;
    s_reg.psr && s_reg.timer_sync_hold |=> s_reg.psr [*2];
  endproperty
  a_psr_hold: assert property (p_psr_hold) else $error("prescaler reset released under hold");

  property p_stopped;
    s_reg.ctrl_b[2:0] == 3'd0 && !wr && s_reg.busy == 5'b00000 |=> $stable(s_reg.cnt);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_count_read;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `ATR_OFF_COUNT
      |-> wb_dat_o[7:0] == $past(s_reg.cnt);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read not live");

  property p_wrap;
    tick && kind == ATR_WK_NORMAL && s_reg.cnt == `ATR_MAX && !wr
      |=> s_reg.cnt == `ATR_BOTTOM && s_reg.flags[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("normal wrap wrong");

  property p_phase_tov;
    $rose(s_reg.flags[0]) && $past(kind) == ATR_WK_PHASE |-> $past(s_reg.cnt) == `ATR_BOTTOM;
  endproperty
  a_phase_tov: assert property (p_phase_tov) else $error("phase overflow not at zero");

  property p_blocked;
    tick && s_reg.blk |-> !hit_a && !hit_b;
  endproperty
  a_blocked: assert property (p_blocked) else $error("match after counter write");

  c_force: cover property (force_a ##1 wave_out_a_en_o);
  c_async: cover property (s_reg.busy[`ATR_BUSY_CNT] ##[1:100] !s_reg.busy[`ATR_BUSY_CNT]);
  c_irq: cover property ($rose(irq_req_o[1]));
  c_phase: cover property (kind == ATR_WK_PHASE && tov);

endmodule : atr_timer
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "atr_cfg.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic ce_i = 1'b1;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic osc_pin_i = 1'b0;
  logic global_irq_en_i = 1'b0;
  logic [2:0] irq_vector_ack_i = 3'h0;
  logic [2:0] irq_req_o;
  logic wave_out_a_o, wave_out_a_en_o, wave_out_b_o, wave_out_b_en_o;
  logic ext_clk_buf_en_o, xtal_osc_en_o;
  int fail_count = 0;
  int checks = 0;

  always #2 clk_i = ~clk_i;

  atr_timer i_atr_timer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_pin_i(osc_pin_i),
    .global_irq_en_i(global_irq_en_i), .irq_vector_ack_i(irq_vector_ack_i),
    .irq_req_o(irq_req_o), .wave_out_a_o(wave_out_a_o), .wave_out_a_en_o(wave_out_a_en_o),
    .wave_out_b_o(wave_out_b_o), .wave_out_b_en_o(wave_out_b_en_o),
    .ext_clk_buf_en_o(ext_clk_buf_en_o), .xtal_osc_en_o(xtal_osc_en_o));

  // ----------------------------------------
  // Compare and bus helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input logic [7:0] got);
    checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fail_count++;
      $display("mismatch %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask : chk_rng

  // Ack and data read at the rising edge, before the design's registers update
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                    output logic [7:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, wd};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [7:0] d;
    wb(1'b1, adr, wd, d);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] d;
    wb(1'b0, adr, 8'h00, d);
    chk(what, exp, d);
  endtask : rd_chk

  task automatic settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic osc_pulse;
    @(posedge clk_i);
    osc_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    osc_pin_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : osc_pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk("ctrl_b", `ATR_OFF_CTRL_B, 8'h00);
    rd_chk("flags", `ATR_OFF_FLAGS, 8'h00);
    wr(8'h24, 8'hff);
    rd_chk("unmapped", 8'h24, 8'h00);
  endtask : t_reset

  task automatic t_force;
    wr(`ATR_OFF_CTRL_A, 8'h50);
    wr(`ATR_OFF_CTRL_B, 8'hf0);
    rd_chk("ctrl_b readback", `ATR_OFF_CTRL_B, 8'h00);
    settle();
    chk("pins after force", 8'h0f, {wave_out_a_en_o, wave_out_a_o, wave_out_b_en_o, wave_out_b_o});
    wr(`ATR_OFF_CTRL_B, 8'h80);
    settle();
    chk("pins force a only", 8'h0b, {wave_out_a_en_o, wave_out_a_o, wave_out_b_en_o, wave_out_b_o});
    rd_chk("flags after force", `ATR_OFF_FLAGS, 8'h00);
    rd_chk("count after force", `ATR_OFF_COUNT, 8'h00);
    wr(`ATR_OFF_CTRL_A, 8'hf1);
    wr(`ATR_OFF_CTRL_B, 8'hc0);
    settle();
    chk("pwm ignores force", 8'h01, {6'h0, wave_out_a_o, wave_out_b_o});
    wr(`ATR_OFF_CTRL_B, 8'h00);
    wr(`ATR_OFF_CTRL_A, 8'h00);
  endtask : t_force

  task automatic t_irq;
    wr(`ATR_OFF_CMP_A, 8'h10);
    wr(`ATR_OFF_CMP_B, 8'h20);
    wr(`ATR_OFF_IEN, 8'h07);
    global_irq_en_i <= 1'b1;
    wr(`ATR_OFF_CTRL_B, 8'h01);
    repeat (300) @(posedge clk_i);
    wr(`ATR_OFF_CTRL_B, 8'h00);
    rd_chk("flags after wrap", `ATR_OFF_FLAGS, 8'h07);
    settle();
    chk("irq all", 8'h07, {5'h0, irq_req_o});
    global_irq_en_i <= 1'b0;
    settle();
    chk("irq global off", 8'h00, {5'h0, irq_req_o});
    global_irq_en_i <= 1'b1;
    wr(`ATR_OFF_FLAGS, 8'h01);
    rd_chk("flags w1c", `ATR_OFF_FLAGS, 8'h06);
    @(posedge clk_i);
    irq_vector_ack_i <= 3'b010;
    @(posedge clk_i);
    irq_vector_ack_i <= 3'b000;
    rd_chk("flags vector", `ATR_OFF_FLAGS, 8'h04);
    wr(`ATR_OFF_IEN, 8'h00);
    settle();
    chk("irq masked", 8'h00, {5'h0, irq_req_o});
    wr(`ATR_OFF_FLAGS, 8'h07);
  endtask : t_irq

  task automatic t_block;
    logic [7:0] d;
    wr(`ATR_OFF_COUNT, 8'h10);
    wr(`ATR_OFF_CTRL_B, 8'h01);
    repeat (5) @(posedge clk_i);
    wr(`ATR_OFF_CTRL_B, 8'h00);
    rd_chk("flags blocked", `ATR_OFF_FLAGS, 8'h00);
    wb(1'b0, `ATR_OFF_COUNT, 8'h00, d);
    chk_rng("count live", 8'h13, 8'h1c, d);
    wr(`ATR_OFF_COUNT, 8'h0e);
    wr(`ATR_OFF_CTRL_B, 8'h01);
    repeat (5) @(posedge clk_i);
    wr(`ATR_OFF_CTRL_B, 8'h00);
    rd_chk("flags unblocked", `ATR_OFF_FLAGS, 8'h02);
    wr(`ATR_OFF_FLAGS, 8'h07);
  endtask : t_block

  task automatic t_presc;
    int div [7] = '{1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] d;
    logic [7:0] e;
    for (int c = 1; c <= 7; c++) begin
      wr(`ATR_OFF_COUNT, 8'h00);
      wr(`ATR_OFF_CTRL_B, c[7:0]);
      repeat (10 * div[c-1]) @(posedge clk_i);
      wr(`ATR_OFF_CTRL_B, 8'h00);
      wb(1'b0, `ATR_OFF_COUNT, 8'h00, d);
      chk_rng("prescaled count", 10, (10 * div[c-1] + 14) / div[c-1] + 1, d);
    end
    repeat (20) @(posedge clk_i);
    wb(1'b0, `ATR_OFF_COUNT, 8'h00, e);
    chk("stopped count", d, e);
    wr(`ATR_OFF_GEN, 8'h02);
    rd_chk("psr sync", `ATR_OFF_GEN, 8'h00);
  endtask : t_presc

  // Clock enable low must freeze the counter
  task automatic t_freeze;
    logic [7:0] d;
    wr(`ATR_OFF_COUNT, 8'h00);
    wr(`ATR_OFF_CTRL_B, 8'h01);
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (50) @(posedge clk_i);
    ce_i <= 1'b1;
    wr(`ATR_OFF_CTRL_B, 8'h00);
    wb(1'b0, `ATR_OFF_COUNT, 8'h00, d);
    chk_rng("count frozen", 1, 8, d);
  endtask : t_freeze

  // Run last: leaving async mode may corrupt timer registers
  task automatic t_async;
    wr(`ATR_OFF_ASYNC, 8'h40);
    wr(`ATR_OFF_ASYNC, 8'h60);
    settle();
    chk("ext buffer", 8'h02, {6'h0, ext_clk_buf_en_o, xtal_osc_en_o});
    wr(`ATR_OFF_CMP_B, 8'h33);
    rd_chk("busy set", `ATR_OFF_ASYNC, 8'h64);
    rd_chk("cmp_b temp", `ATR_OFF_CMP_B, 8'h33);
    osc_pulse();
    rd_chk("busy clear", `ATR_OFF_ASYNC, 8'h60);
    wr(`ATR_OFF_GEN, 8'h02);
    rd_chk("psr async held", `ATR_OFF_GEN, 8'h02);
    osc_pulse();
    rd_chk("psr async done", `ATR_OFF_GEN, 8'h00);
    wr(`ATR_OFF_GEN, 8'h82);
    osc_pulse();
    osc_pulse();
    rd_chk("psr sync hold", `ATR_OFF_GEN, 8'h82);
    wr(`ATR_OFF_GEN, 8'h00);
    wr(`ATR_OFF_ASYNC, 8'h20);
    settle();
    chk("crystal", 8'h01, {6'h0, ext_clk_buf_en_o, xtal_osc_en_o});
    wr(`ATR_OFF_ASYNC, 8'h00);
  endtask : t_async

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_force();
    t_irq();
    t_block();
    t_presc();
    t_freeze();
    t_async();
    results();
  end
endmodule : tb_top
`default_nettype wire
